/* File: dv/srg_ctrl_model.sv */
// Controller model: issues setting, query and clear commands.
// Assumes the block answers a query on the following edge.
`timescale 1ns/1ps
module srg_ctrl_model (
	// Clock
	input  wire logic        clock,
	// Command port
	output logic             cmd_wr,
	output logic             cmd_rd,
	output logic [1:0]       cmd_group,
	output logic [2:0]       cmd_reg,
	output logic [15:0]      cmd_wdata,
	output logic             clear_status,
	// Answer
	input  wire logic [15:0] rd_data,
	input  wire logic        rd_valid
);
	initial {cmd_wr, cmd_rd, cmd_group, cmd_reg, cmd_wdata, clear_status} = '0;
	// One strobe per command; idle write data inverted so nothing stale looks valid
	task automatic issue(input logic w, input logic [1:0] g, input logic [2:0] r, input logic [15:0] d,
		output logic [15:0] q, output logic v);
		@(posedge clock);
		#1;
		cmd_wr = w;
		cmd_rd = !w;
		cmd_group = g;
		cmd_reg = r;
		cmd_wdata = d;
		@(posedge clock);
		#1;
		q = rd_data; // Answer launched by the edge that took the query
		v = rd_valid;
		cmd_wr = 1'b0;
		cmd_rd = 1'b0;
		cmd_wdata = ~d;
	endtask
	// Clear-status pulse
	task automatic cls();
		@(posedge clock);
		#1;
		clear_status = 1'b1;
		@(posedge clock);
		#1;
		clear_status = 1'b0;
	endtask
endmodule // srg_ctrl_model

/* File: dv/srg_top_sva.sv */
// Checker for srg_top: answer timing and reserved bits.
// Sees only the top ports; bound below.
`timescale 1ns/1ps
module srg_top_sva (
	// Clock and reset
	input wire logic        clock,
	input wire logic        resetn,
	// Query and answer
	input wire logic        cmd_rd,
	input wire logic [1:0]  cmd_group,
	input wire logic [2:0]  cmd_reg,
	input wire logic [15:0] rd_data,
	input wire logic        rd_valid
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	// Answer timing
	property p_ans; cmd_rd |=> rd_valid; endproperty
	a_ans: assert property (p_ans) else $error("query not answered");
	property p_quiet; !cmd_rd |=> !rd_valid; endproperty
	a_quiet: assert property (p_quiet) else $error("answer without query");
	property p_hold; !rd_valid |-> $stable(rd_data); endproperty
	a_hold: assert property (p_hold) else $error("answer moved");
	// Reserved and unused bits
	property p_b15; rd_valid |-> !rd_data[15]; endproperty
	a_b15: assert property (p_b15) else $error("bit 15 set");
	property p_meas; rd_valid && $past(cmd_group) == 2'h0 |-> rd_data[15:3] == 13'h0; endproperty
	a_meas: assert property (p_meas) else $error("measuring unused bit set");
	property p_olr; rd_valid && $past(cmd_group) == 2'h1 |-> rd_data[15:3] == 13'h0; endproperty
	a_olr: assert property (p_olr) else $error("open-loop unused bit set");
	property p_oper; rd_valid && $past(cmd_group) == 2'h2 |-> (rd_data & ~srg_pkg::OPER_MASK) == 16'h0; endproperty
	a_oper: assert property (p_oper) else $error("operation unused bit set");
	property p_none; cmd_rd && (cmd_group == 2'h3 || cmd_reg > 3'h4) |=> rd_data == 16'h0; endproperty
	a_none: assert property (p_none) else $error("empty place not zero");
endmodule // srg_top_sva

bind srg_top srg_top_sva u_sva (.clock(clock), .resetn(resetn), .cmd_rd(cmd_rd), .cmd_group(cmd_group),
	.cmd_reg(cmd_reg), .rd_data(rd_data), .rd_valid(rd_valid));

/* File: dv/tb.sv */
// Testbench for srg_top: reset values, filters, events, summaries.
// Assumes the controller model drives the command port.
`timescale 1ns/1ps
module tb;
	logic        clock = 1'b0;
	logic        resetn = 1'b0;
	logic        cmd_wr, cmd_rd, clear_status, rd_valid, sb7, olr_sum, v;
	logic [1:0]  cmd_group;
	logic [2:0]  cmd_reg;
	logic [15:0] cmd_wdata, rd_data, q;
	logic [2:0]  meas = '0; // error-rate, open-loop, gated power
	logic [2:0]  olr = '0;  // running, passed, failed
	logic [7:0]  op = '0;   // cal, range, radio, callp, radio2, progc, timebase, prog
	int          bad_count = 0;
	int          n_tests = 0;
	int          cyc = 0;
	logic [15:0] mk [3] = '{srg_pkg::MEAS_MASK, srg_pkg::OLR_MASK, srg_pkg::OPER_MASK};
	always #4 clock = ~clock;
	// Block and controller
	srg_top u_dut (.clock(clock), .resetn(resetn), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_group(cmd_group),
		.cmd_reg(cmd_reg), .cmd_wdata(cmd_wdata), .clear_status(clear_status),
		.frame_error_rate_running(meas[0]), .open_loop_running_meas(meas[1]), .gated_power_running(meas[2]),
		.open_loop_response_running(olr[0]), .open_loop_response_passed(olr[1]),
		.open_loop_response_failed(olr[2]), .calibration_summary(op[0]), .ranging_error(op[1]),
		.radio_summary(op[2]), .call_processing_summary(op[3]), .second_radio_group_summary(op[4]),
		.program_group_summary(op[5]), .external_timebase_in_use(op[6]), .program_running(op[7]),
		.rd_data(rd_data), .rd_valid(rd_valid), .status_byte_bit7(sb7), .open_loop_response_summary(olr_sum));
	srg_ctrl_model u_ctrl (.clock(clock), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_group(cmd_group),
		.cmd_reg(cmd_reg), .cmd_wdata(cmd_wdata), .clear_status(clear_status), .rd_data(rd_data),
		.rd_valid(rd_valid));
	// Helpers
	task automatic close_out();
		$display("Checks %0d, mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic rd(input string nm, input logic [1:0] g, input logic [2:0] r, input logic [15:0] exp);
		u_ctrl.issue(1'b0, g, r, 16'h0, q, v);
		check({nm, " valid"}, {15'h0, v}, 16'h1);
		check(nm, q, exp);
	endtask
	task automatic wr(input logic [1:0] g, input logic [2:0] r, input logic [15:0] d);
		u_ctrl.issue(1'b1, g, r, d, q, v);
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	// Reset values and empty places
	task automatic t_reset();
		for (int g = 0; g < 3; g++)
		begin
			rd("pos filter", 2'(g), srg_pkg::REG_PTR, mk[g]);
			rd("neg filter", 2'(g), srg_pkg::REG_NTR, 16'h0);
			rd("enable", 2'(g), srg_pkg::REG_ENAB, 16'h0);
		end
		rd("no group", 2'h3, srg_pkg::REG_ENAB, 16'h0);
		rd("no register", srg_pkg::GRP_OPER, 3'h5, 16'h0);
	endtask
	// Filter and enable writes keep only used bits
	task automatic t_filt();
		for (int g = 0; g < 3; g++)
		begin
			wr(2'(g), srg_pkg::REG_NTR, 16'hffff);
			rd("neg filter", 2'(g), srg_pkg::REG_NTR, mk[g]);
			wr(2'(g), srg_pkg::REG_NTR, 16'h0);
			wr(2'(g), srg_pkg::REG_ENAB, 16'hffff);
			rd("enable", 2'(g), srg_pkg::REG_ENAB, mk[g]);
		end
		wr(srg_pkg::GRP_OLR, srg_pkg::REG_PTR, 16'h0002);
		rd("olr pos filter", srg_pkg::GRP_OLR, srg_pkg::REG_PTR, 16'h0002);
	endtask
	// Open-loop running, passed and failed events
	task automatic t_olr();
		wr(srg_pkg::GRP_OLR, srg_pkg::REG_PTR, 16'h0001);
		wr(srg_pkg::GRP_OLR, srg_pkg::REG_NTR, 16'h0001);
		wr(srg_pkg::GRP_OLR, srg_pkg::REG_ENAB, 16'h0004);
		olr = 3'b011;
		step(1);
		olr[1] = 1'b0;
		step(3);
		check("olr summary", {15'h0, olr_sum}, 16'h0);
		rd("olr cond", srg_pkg::GRP_OLR, srg_pkg::REG_COND, 16'h0001);
		rd("olr event", srg_pkg::GRP_OLR, srg_pkg::REG_EVEN, 16'h0003);
		rd("olr event again", srg_pkg::GRP_OLR, srg_pkg::REG_EVEN, 16'h0);
		olr = 3'b100;
		step(1);
		olr = 3'b000;
		step(3);
		check("olr summary", {15'h0, olr_sum}, 16'h1);
		rd("olr event fall", srg_pkg::GRP_OLR, srg_pkg::REG_EVEN, 16'h0005);
		step(3);
		check("olr summary clear", {15'h0, olr_sum}, 16'h0);
	endtask
	// Operation conditions and the status byte path
	task automatic t_oper();
		wr(srg_pkg::GRP_OPER, srg_pkg::REG_ENAB, 16'h0010);
		meas = 3'b001;
		op = 8'hff;
		step(1);
		op[1] = 1'b0;
		step(8);
		check("status bit7", {15'h0, sb7}, 16'h1);
		rd("meas cond", srg_pkg::GRP_MEAS, srg_pkg::REG_COND, 16'h0001);
		rd("oper cond", srg_pkg::GRP_OPER, srg_pkg::REG_COND, 16'h5f11);
		rd("oper event", srg_pkg::GRP_OPER, srg_pkg::REG_EVEN, 16'h5f15);
		step(3);
		check("status bit7 off", {15'h0, sb7}, 16'h0);
		u_ctrl.cls();
		rd("meas event", srg_pkg::GRP_MEAS, srg_pkg::REG_EVEN, 16'h0);
	endtask
	// Hang guard
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			bad_count++;
			close_out();
		end
	end
	initial
	begin
		step(16);
		resetn = 1'b1;
		t_reset();
		t_filt();
		t_olr();
		t_oper();
		close_out();
	end
endmodule // tb

/* File: src/srg_group.sv */
// One status group: condition, transition filters, event latch, enable mask.
// Assumes inputs come from logic on the same clock; one command strobe at a time.
`timescale 1ns/1ps
module srg_group #(
	parameter logic [15:0] MASK   = 16'hffff,
	parameter logic [15:0] EVONLY = 16'h0000
) (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        resetn,
	// Status sources
	input  wire logic [15:0] cond_in,
	input  wire logic [15:0] ev_pulse,
	// Register access
	input  wire logic        sel,
	input  wire logic        wr,
	input  wire logic        rd,
	input  wire logic [2:0]  reg_sel,
	input  wire logic [15:0] wdata,
	input  wire logic        clear_all,
	// Results
	output logic      [15:0] rdata,
	output logic             group_summary_bit
);
	logic [15:0] cond_r, ptr_r, ntr_r, even_r, enab_r;
	logic [15:0] cond_nxt, rise, fall, ev_set, even_nxt;
	wire         do_wr     = sel & wr;
	wire         even_read = sel & rd & (reg_sel == srg_pkg::REG_EVEN);

	// Condition storage only for condition-implemented bits
	assign cond_nxt = cond_in & MASK & ~EVONLY;
	assign rise     = cond_nxt & ~cond_r;
	assign fall     = ~cond_nxt & cond_r;
	// Edge filters and event-only pulses, masked to used bits
	assign ev_set   = ((rise & ptr_r) | (fall & ntr_r) | (ev_pulse & EVONLY)) & MASK;   // [RL17] [RL6] [RL7]
	// Set wins over a clear by query or clear-status
	assign even_nxt = ((even_read | clear_all) ? srg_pkg::ZERO : even_r) | ev_set;    // [RL3] [RL17]

	// Register updates
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			cond_r <= srg_pkg::ZERO;
			ptr_r  <= srg_pkg::PTR_RST & MASK;              // [RL5] [RL6]
			ntr_r  <= srg_pkg::NTR_RST;
			even_r <= srg_pkg::ZERO;
			enab_r <= srg_pkg::ENAB_RST;
		end
		else
		begin
			cond_r <= cond_nxt;
			even_r <= even_nxt;
			if (do_wr && reg_sel == srg_pkg::REG_PTR)
				ptr_r <= wdata & MASK;                          // [RL2] [RL5]
			if (do_wr && reg_sel == srg_pkg::REG_NTR)
				ntr_r <= wdata & MASK;                          // [RL2]
			if (do_wr && reg_sel == srg_pkg::REG_ENAB)
				enab_r <= wdata & MASK;                         // [RL4]
		end
	end

	// Read mux and summary
	always_comb
	begin
		case (reg_sel)
			srg_pkg::REG_COND: rdata = cond_r;                  // [RL1]
			srg_pkg::REG_PTR:  rdata = ptr_r;                   // [RL2]
			srg_pkg::REG_NTR:  rdata = ntr_r;                   // [RL2]
			srg_pkg::REG_EVEN: rdata = even_r;                  // [RL1]
			srg_pkg::REG_ENAB: rdata = enab_r;                  // [RL4]
			default:           rdata = srg_pkg::ZERO;
		endcase
	end
	assign group_summary_bit = |(even_r & enab_r);              // [RL18]
endmodule // srg_group

/* File: src/srg_pkg.sv */
// Package for the status register groups block: group, register and bit constants.
// Assumes a command decoder upstream that turns status commands into strobes.
package srg_pkg;
	localparam int W = 16;
	// Groups addressed by the command port
	localparam logic [1:0] GRP_MEAS = 2'h0;
	localparam logic [1:0] GRP_OLR  = 2'h1;
	localparam logic [1:0] GRP_OPER = 2'h2;
	// Registers within a group
	localparam logic [2:0] REG_COND = 3'h0;
	localparam logic [2:0] REG_PTR  = 3'h1;
	localparam logic [2:0] REG_NTR  = 3'h2;
	localparam logic [2:0] REG_EVEN = 3'h3;
	localparam logic [2:0] REG_ENAB = 3'h4;
	// Reset values
	localparam logic [15:0] PTR_RST  = 16'h7fff;
	localparam logic [15:0] NTR_RST  = 16'h0000;
	localparam logic [15:0] ENAB_RST = 16'h0000;
	localparam logic [15:0] ZERO     = 16'h0000;
	// Implemented bit masks per group (bit 15 never set)
	localparam logic [15:0] MEAS_MASK = 16'h0007;
	localparam logic [15:0] OLR_MASK  = 16'h0007;
	localparam logic [15:0] OPER_MASK = 16'h5f15;
	// Event-only bits, fed by pulses instead of a condition
	localparam logic [15:0] OLR_EVONLY  = 16'h0006;
	localparam logic [15:0] OPER_EVONLY = 16'h0004;
	// Bit positions
	localparam int OLR_RUN  = 0;
	localparam int OLR_PASS = 1;
	localparam int OLR_FAIL = 2;
	localparam int OP_CAL   = 0;
	localparam int OP_RANGE = 2;
	localparam int OP_MEAS  = 4;
	localparam int OP_RADIO = 8;
	localparam int OP_CALLP = 9;
	localparam int OP_RAD2  = 10;
	localparam int OP_PROGC = 11;
	localparam int OP_XTB   = 12;
	localparam int OP_PROG  = 14;
	localparam int ME_FER   = 0;
	localparam int ME_OLR   = 1;
	localparam int ME_GPWR  = 2;
endpackage

/* File: src/srg_top.sv */
// Top of the status register groups: measuring, open-loop response, operation.
// Assumes a command decoder on the same clock presents one strobe per command
// and takes the answer from rd_data when rd_valid is high.
//
// Overview of operation
// RL1: Every group register reachable by query/setting commands
// RL2: Filter setting loads value; filter query returns it
// RL3: Event query or clear-status zeroes the event register
// RL4: Enable setting loads mask; enable query returns it
// RL5: Bit fifteen always reads zero
// RL6: Unused open-loop and operation bits never set
// RL7: Open-loop: running condition, pass/fail event-only bits
// RL8: Open-loop group tracks only its own measurement
// RL9: Operation bit 14: program executing condition
// RL10: Operation bit 12: external timebase in use
// RL11: Operation bits 11..8: other groups' summaries
// RL12: Operation bit 4 measuring, bit 0 calibration summary
// RL13: Operation bit 2: ranging error, event-only
// RL14: Operation summary drives status byte bit seven
// RL15: Measuring summary reaches byte via operation enable
// RL16: Measuring bits: error-rate, open-loop, gated power running
// RL17: Event latches on filtered edge until cleared
// RL18: Summary is OR of event AND enable
`timescale 1ns/1ps
module srg_top (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        resetn,
	// Command port
	input  wire logic        cmd_wr,
	input  wire logic        cmd_rd,
	input  wire logic [1:0]  cmd_group,
	input  wire logic [2:0]  cmd_reg,
	input  wire logic [15:0] cmd_wdata,
	input  wire logic        clear_status,
	// Measuring conditions
	input  wire logic        frame_error_rate_running,
	input  wire logic        open_loop_running_meas,
	input  wire logic        gated_power_running,
	// Open-loop response group sources
	input  wire logic        open_loop_response_running,
	input  wire logic        open_loop_response_passed,
	input  wire logic        open_loop_response_failed,
	// Operation sources
	input  wire logic        calibration_summary,
	input  wire logic        ranging_error,
	input  wire logic        radio_summary,
	input  wire logic        call_processing_summary,
	input  wire logic        second_radio_group_summary,
	input  wire logic        program_group_summary,
	input  wire logic        external_timebase_in_use,
	input  wire logic        program_running,
	// Answers and status byte link
	output logic [15:0]      rd_data,
	output logic             rd_valid,
	output logic             status_byte_bit7,
	output logic             open_loop_response_summary
);
	logic [15:0] meas_cond, olr_cond, olr_pulse, oper_cond, oper_pulse;
	logic [15:0] meas_rd, olr_rd, oper_rd, sel_rd;
	logic        meas_sum, olr_sum, oper_sum;
	logic [15:0] rd_data_r;
	logic        rd_valid_r, sb7_r, olr_sum_r;
	wire         sel_meas = (cmd_group == srg_pkg::GRP_MEAS);
	wire         sel_olr  = (cmd_group == srg_pkg::GRP_OLR);
	wire         sel_oper = (cmd_group == srg_pkg::GRP_OPER);

	// Measuring group condition inputs
	always_comb
	begin
		meas_cond                  = srg_pkg::ZERO;
		meas_cond[srg_pkg::ME_FER]  = frame_error_rate_running;    // [RL16]
		meas_cond[srg_pkg::ME_OLR]  = open_loop_running_meas;      // [RL16]
		meas_cond[srg_pkg::ME_GPWR] = gated_power_running;         // [RL16]
	end

	// Open-loop response group: only its own measurement feeds it
	always_comb
	begin
		olr_cond                    = srg_pkg::ZERO;
		olr_pulse                   = srg_pkg::ZERO;
		olr_cond[srg_pkg::OLR_RUN]   = open_loop_response_running; // [RL7] [RL8]
		olr_pulse[srg_pkg::OLR_PASS] = open_loop_response_passed;  // [RL7]
		olr_pulse[srg_pkg::OLR_FAIL] = open_loop_response_failed;  // [RL7]
	end

	// Operation group inputs, measuring summary on bit 4
	always_comb
	begin
		oper_cond                    = srg_pkg::ZERO;
		oper_pulse                   = srg_pkg::ZERO;
		oper_cond[srg_pkg::OP_CAL]    = calibration_summary;        // [RL12]
		oper_cond[srg_pkg::OP_MEAS]   = meas_sum;                   // [RL12] [RL15]
		oper_cond[srg_pkg::OP_RADIO]  = radio_summary;              // [RL11]
		oper_cond[srg_pkg::OP_CALLP]  = call_processing_summary;    // [RL11]
		oper_cond[srg_pkg::OP_RAD2]   = second_radio_group_summary; // [RL11]
		oper_cond[srg_pkg::OP_PROGC]  = program_group_summary;      // [RL11]
		oper_cond[srg_pkg::OP_XTB]    = external_timebase_in_use;   // [RL10]
		oper_cond[srg_pkg::OP_PROG]   = program_running;            // [RL9]
		oper_pulse[srg_pkg::OP_RANGE] = ranging_error;              // [RL13]
	end

	// Measuring group
	srg_group #(
		.MASK   (srg_pkg::MEAS_MASK),
		.EVONLY (srg_pkg::ZERO)
	) u_meas (
		.clock             (clock),
		.resetn            (resetn),
		.cond_in           (meas_cond),
		.ev_pulse          (srg_pkg::ZERO),
		.sel               (sel_meas),
		.wr                (cmd_wr),
		.rd                (cmd_rd),
		.reg_sel           (cmd_reg),
		.wdata             (cmd_wdata),
		.clear_all         (clear_status),
		.rdata             (meas_rd),
		.group_summary_bit (meas_sum)
	);

	// Open-loop response group
	srg_group #(
		.MASK   (srg_pkg::OLR_MASK),
		.EVONLY (srg_pkg::OLR_EVONLY)
	) u_olr (
		.clock             (clock),
		.resetn            (resetn),
		.cond_in           (olr_cond),
		.ev_pulse          (olr_pulse),
		.sel               (sel_olr),
		.wr                (cmd_wr),
		.rd                (cmd_rd),
		.reg_sel           (cmd_reg),
		.wdata             (cmd_wdata),
		.clear_all         (clear_status),
		.rdata             (olr_rd),
		.group_summary_bit (olr_sum)
	);

	// Operation group
	srg_group #(
		.MASK   (srg_pkg::OPER_MASK),
		.EVONLY (srg_pkg::OPER_EVONLY)
	) u_oper (
		.clock             (clock),
		.resetn            (resetn),
		.cond_in           (oper_cond),
		.ev_pulse          (oper_pulse),
		.sel               (sel_oper),
		.wr                (cmd_wr),
		.rd                (cmd_rd),
		.reg_sel           (cmd_reg),
		.wdata             (cmd_wdata),
		.clear_all         (clear_status),
		.rdata             (oper_rd),
		.group_summary_bit (oper_sum)
	);

	// Answer select; unknown group answers zero
	assign sel_rd = sel_meas ? meas_rd :
	                sel_olr  ? olr_rd  :
	                sel_oper ? oper_rd : srg_pkg::ZERO;             // [RL1]

	// Registered outputs
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			rd_data_r  <= srg_pkg::ZERO;
			rd_valid_r <= 1'b0;
			sb7_r      <= 1'b0;
			olr_sum_r  <= 1'b0;
		end
		else
		begin
			rd_valid_r <= cmd_rd;
			if (cmd_rd)
				rd_data_r <= sel_rd;                            // [RL5]
			sb7_r      <= oper_sum;                             // [RL14]
			olr_sum_r  <= olr_sum;
		end
	end

	assign rd_data                    = rd_data_r;
	assign rd_valid                   = rd_valid_r;
	assign status_byte_bit7           = sb7_r;
	assign open_loop_response_summary = olr_sum_r;
endmodule // srg_top
